// >>> vmfcsb_pkg.sv
/*
  Constants for the system register bank: encodings, bus addresses, register slots, reset values.
  Assumes the bank is reached over a 32-bit classic Wishbone slave.
*/
package vmfcsb_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int KEY_W  = 14;
  localparam int SLOT_W = 5;
  localparam int NREG   = 22;
  localparam int NMAINT = 13;

  // Key is {CRn[3:0], Op1[2:0], CRm[3:0], Op2[2:0]}
  function automatic logic [KEY_W-1:0] mk_key(input int crn, input int op1, input int crm, input int op2);
    mk_key = {crn[3:0], op1[2:0], crm[3:0], op2[2:0]};
  endfunction

  // Address bit 16 selects the 64-bit window; key sits in bits 15:2
  localparam int WIDE_BIT = 16;

  localparam logic [KEY_W-1:0] K_SYSCTL   = mk_key(1, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_CPACC    = mk_key(1, 0, 0, 2);
  localparam logic [KEY_W-1:0] K_TB0      = mk_key(2, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_TB1      = mk_key(2, 0, 0, 1);
  localparam logic [KEY_W-1:0] K_TBC      = mk_key(2, 0, 0, 2);
  localparam logic [KEY_W-1:0] K_DAC      = mk_key(3, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_DFS      = mk_key(5, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_IFS      = mk_key(5, 0, 0, 1);
  localparam logic [KEY_W-1:0] K_ADFS     = mk_key(5, 0, 1, 0);
  localparam logic [KEY_W-1:0] K_AIFS     = mk_key(5, 0, 1, 1);
  localparam logic [KEY_W-1:0] K_DFA      = mk_key(6, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_IFA      = mk_key(6, 0, 0, 2);
  localparam logic [KEY_W-1:0] K_PRR      = mk_key(10, 0, 2, 0);
  localparam logic [KEY_W-1:0] K_NMR      = mk_key(10, 0, 2, 1);
  localparam logic [KEY_W-1:0] K_AMA0     = mk_key(10, 0, 3, 0);
  localparam logic [KEY_W-1:0] K_AMA1     = mk_key(10, 0, 3, 1);
  localparam logic [KEY_W-1:0] K_FCSE     = mk_key(13, 0, 0, 0);
  localparam logic [KEY_W-1:0] K_CTXID    = mk_key(13, 0, 0, 1);
  localparam logic [KEY_W-1:0] K_BANKCTL  = mk_key(15, 7, 15, 0);
  localparam logic [KEY_W-1:0] K_BANKSTAT = mk_key(15, 7, 15, 1);
  localparam logic [3:0]       WIDE_CRM   = 4'h2;

  // Storage slots
  localparam logic [SLOT_W-1:0] S_SYSCTL = 5'h00, S_TB0L = 5'h01, S_TB0H = 5'h02, S_TB1L = 5'h03;
  localparam logic [SLOT_W-1:0] S_TB1H   = 5'h04, S_TBCS = 5'h05, S_DAC  = 5'h06, S_PRR  = 5'h07;
  localparam logic [SLOT_W-1:0] S_MAI0   = 5'h08, S_NMR  = 5'h09, S_MAI1 = 5'h0A, S_AMA0 = 5'h0B;
  localparam logic [SLOT_W-1:0] S_AMA1   = 5'h0C, S_CTX  = 5'h0D, S_DFS  = 5'h0E, S_IFS  = 5'h0F;
  localparam logic [SLOT_W-1:0] S_ADFS   = 5'h10, S_AIFS = 5'h11, S_DFA  = 5'h12, S_IFA  = 5'h13;
  localparam logic [SLOT_W-1:0] S_CPACC  = 5'h14, S_FCSE = 5'h15, S_TBCN = 5'h16, S_BCTL = 5'h17;
  localparam logic [SLOT_W-1:0] S_BSTAT  = 5'h18, S_NONE = 5'h1F;

  // Slots that take a value at reset; the rest come up unknown
  localparam logic [NREG-1:0] HAS_RST = 22'h30_02A1;

  localparam logic [31:0] SYSCTL_RST = 32'h00C5_0078;
  localparam logic [31:0] PRR_RST    = 32'h0009_8AA4;
  localparam logic [31:0] NMR_RST    = 32'h44E0_48E0;
  localparam logic [31:0] TBC_RST    = 32'h0000_0000;
  localparam logic [31:0] FCSE_RST   = 32'h0000_0000;
  localparam logic [31:0] CPACC_NOSIMD_RST = 32'h8000_0000;
  localparam logic [31:0] CPACC_RST  = 32'h0000_0000;

  localparam int SYSCTL_TE_BIT = 30;
  localparam int SYSCTL_EE_BIT = 25;
  localparam int SYSCTL_V_BIT  = 13;
  localparam int TBC_EAE_BIT   = 31;

  // Maintenance operation numbers, one bit each on the op output
  localparam logic [3:0] M_IC_ALL_SH = 4'h0, M_BP_ALL_SH = 4'h1, M_IC_ALL = 4'h2, M_IC_ADDR = 4'h3;
  localparam logic [3:0] M_BP_ALL    = 4'h4, M_BP_ADDR   = 4'h5, M_DC_INV_ADDR = 4'h6;
  localparam logic [3:0] M_DC_INV_SW = 4'h7, M_DC_CL_COH = 4'h8, M_DC_CL_SW = 4'h9;
  localparam logic [3:0] M_DC_CL_UNI = 4'hA, M_DC_CI_ADDR = 4'hB, M_DC_CI_SW = 4'hC, M_NONE = 4'hF;

  // Ops that target coherence, and ops that target unification
  localparam logic [NMAINT-1:0] COH_OPS = 13'h0940;
  localparam logic [NMAINT-1:0] UNI_OPS = 13'h040D;

endpackage

// >>> vmfcsb_bank.sv
/*
  Virtual-memory, fault and cache-maintenance system register bank with a classic Wishbone slave.
  Assumes a single clock, synchronous inputs and static configuration inputs stable around reset.
*/
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module vmfcsb_bank #(
  parameter int  DW          = 32,
  parameter bit  FPU_PRESENT = 1'b1,
  parameter bit  SIMD_PRESENT = 1'b1
) (
  input  wire logic                           clk_i,
  input  wire logic                           srst_i,
  input  wire logic                           ce_i,
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [vmfcsb_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [vmfcsb_pkg::DATA_W-1:0]  wb_dat_i,
  output logic      [vmfcsb_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                                wb_ack_o,
  input  wire logic                           exception_state_select_i,
  input  wire logic                           endianness_select_i,
  input  wire logic                           high_vector_select_i,
  input  wire logic                           inner_broadcast_cfg_i,
  output logic      [31:0]                    system_control_o,
  output logic      [31:0]                    translation_base_control_o,
  output logic      [vmfcsb_pkg::NMAINT-1:0]  maint_op_o,
  output logic      [31:0]                    maint_data_o,
  output logic                                maint_external_o,
  output logic                                pou_external_o
);
  import vmfcsb_pkg::*;

  if (DW != DATA_W) begin : g_dw_check
    $error("vmfcsb_bank: data width must be 32");
  end

  logic [31:0]       regs_q [NREG];
  logic              ns_eae_reg;
  logic [30:0]       ns_rest_reg;
  logic              nonsecure_view_reg;
  logic [7:0]        maint_count_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [NMAINT-1:0] maint_op_reg;
  logic [31:0]       maint_data_reg;
  logic              maint_ext_reg;
  logic              pou_ext_reg;
  logic [31:0]       tbc_active_reg;

  logic              req;
  logic              wr;
  logic              rd;
  logic [KEY_W-1:0]  key;
  logic              wide;
  logic              eae_now;
  logic [SLOT_W-1:0] slot;
  logic [3:0]        mop;
  logic [31:0]       wmask;
  logic [31:0]       tbc_ns;

  assign req    = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr     = req && wb_we_i;
  assign rd     = req && !wb_we_i;
  assign key    = wb_adr_i[KEY_W+1:2];
  assign wide   = wb_adr_i[WIDE_BIT];
  assign tbc_ns = {ns_eae_reg, ns_rest_reg};

  // Extended-address view of the active copy picks the shared encodings
  assign eae_now = nonsecure_view_reg ? ns_eae_reg : regs_q[S_TBCS][TBC_EAE_BIT];

  function automatic logic [SLOT_W-1:0] reg_slot(input logic w, input logic [KEY_W-1:0] k,
                                                 input logic ns, input logic eae);
    logic [2:0] op1;
    logic [3:0] crm;
    op1 = k[9:7];
    crm = k[6:3];
    reg_slot = S_NONE;
    if (w) begin
      if (crm == WIDE_CRM && op1 == 3'h0) begin
        reg_slot = k[0] ? S_TB0H : S_TB0L;
      end else if (crm == WIDE_CRM && op1 == 3'h1) begin
        reg_slot = k[0] ? S_TB1H : S_TB1L;
      end
    end else begin
      case (k)
        K_SYSCTL:   reg_slot = S_SYSCTL;
        K_TB0:      reg_slot = S_TB0L;
        K_TB1:      reg_slot = S_TB1L;
        K_TBC:      reg_slot = ns ? S_TBCN : S_TBCS;
        K_DAC:      reg_slot = S_DAC;
        K_PRR:      reg_slot = eae ? S_MAI0 : S_PRR;
        K_NMR:      reg_slot = eae ? S_MAI1 : S_NMR;
        K_AMA0:     reg_slot = S_AMA0;
        K_AMA1:     reg_slot = S_AMA1;
        K_CTXID:    reg_slot = S_CTX;
        K_FCSE:     reg_slot = S_FCSE;
        K_DFS:      reg_slot = S_DFS;
        K_IFS:      reg_slot = S_IFS;
        K_ADFS:     reg_slot = S_ADFS;
        K_AIFS:     reg_slot = S_AIFS;
        K_DFA:      reg_slot = S_DFA;
        K_IFA:      reg_slot = S_IFA;
        K_CPACC:    reg_slot = S_CPACC;
        K_BANKCTL:  reg_slot = S_BCTL;
        K_BANKSTAT: reg_slot = S_BSTAT;
        default:    reg_slot = S_NONE;
      endcase
    end
  endfunction

  function automatic logic [3:0] maint_decode(input logic w, input logic [KEY_W-1:0] k);
    maint_decode = M_NONE;
    if (!w) begin
      case (k)
        mk_key(7, 0, 1, 0):  maint_decode = M_IC_ALL_SH;
        mk_key(7, 0, 1, 6):  maint_decode = M_BP_ALL_SH;
        mk_key(7, 0, 5, 0):  maint_decode = M_IC_ALL;
        mk_key(7, 0, 5, 1):  maint_decode = M_IC_ADDR;
        mk_key(7, 0, 5, 6):  maint_decode = M_BP_ALL;
        mk_key(7, 0, 5, 7):  maint_decode = M_BP_ADDR;
        mk_key(7, 0, 6, 1):  maint_decode = M_DC_INV_ADDR;
        mk_key(7, 0, 6, 2):  maint_decode = M_DC_INV_SW;
        mk_key(7, 0, 10, 1): maint_decode = M_DC_CL_COH;
        mk_key(7, 0, 10, 2): maint_decode = M_DC_CL_SW;
        mk_key(7, 0, 11, 1): maint_decode = M_DC_CL_UNI;
        mk_key(7, 0, 14, 1): maint_decode = M_DC_CI_ADDR;
        mk_key(7, 0, 14, 2): maint_decode = M_DC_CI_SW;
        default:             maint_decode = M_NONE;
      endcase
    end
  endfunction

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] reset_value(input int idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      S_SYSCTL: begin
        v = SYSCTL_RST;
        v[SYSCTL_TE_BIT] = exception_state_select_i;
        v[SYSCTL_EE_BIT] = endianness_select_i;
        v[SYSCTL_V_BIT]  = high_vector_select_i;
      end
      S_TBCS:  v = TBC_RST;
      S_PRR:   v = PRR_RST;
      S_NMR:   v = NMR_RST;
      S_FCSE:  v = FCSE_RST;
      S_CPACC: v = (FPU_PRESENT && !SIMD_PRESENT) ? CPACC_NOSIMD_RST : CPACC_RST;
      default: v = 32'h0000_0000;
    endcase
    reset_value = v;
  endfunction

  assign slot  = reg_slot(wide, key, nonsecure_view_reg, eae_now);
  assign mop   = maint_decode(wide, key);
  assign wmask = byte_mask(wb_sel_i);

  // Stored registers; slots outside the reset mask keep whatever they held
  for (genvar i = 0; i < NREG; i++) begin : g_regs
    always_ff @(posedge clk_i) begin
      if (ce_i) begin
        if (srst_i && HAS_RST[i]) begin
          regs_q[i] <= reset_value(i);
        end else if (!srst_i && wr && slot == SLOT_W'(i)) begin
          regs_q[i] <= (regs_q[i] & ~wmask) | (wb_dat_i & wmask);
        end
      end
    end
  end

  // Non-secure control copy: only the extended-address bit resets
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        ns_eae_reg <= 1'b0;
      end else if (wr && slot == S_TBCN && wb_sel_i[3]) begin
        ns_eae_reg <= wb_dat_i[TBC_EAE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && !srst_i && wr && slot == S_TBCN) begin
      ns_rest_reg <= (ns_rest_reg & ~wmask[30:0]) | (wb_dat_i[30:0] & wmask[30:0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        nonsecure_view_reg <= 1'b0;
      end else if (wr && slot == S_BCTL && wb_sel_i[0]) begin
        nonsecure_view_reg <= wb_dat_i[0];
      end
    end
  end

  // Wishbone answer: one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        ack_reg <= 1'b0;
      end else begin
        ack_reg <= req;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        rdata_reg <= 32'h0000_0000;
      end else if (rd) begin
        case (slot)
          S_NONE:  rdata_reg <= 32'h0000_0000;
          S_TBCN:  rdata_reg <= tbc_ns;
          S_BCTL:  rdata_reg <= {31'h0000_0000, nonsecure_view_reg};
          S_BSTAT: rdata_reg <= {16'h0000, maint_count_reg, 5'h00, nonsecure_view_reg, eae_now, pou_ext_reg};
          default: rdata_reg <= regs_q[slot];
        endcase
      end
    end
  end

  // Maintenance ops fire only on writes, one pulse per accepted 32-bit write to a maintenance encoding
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        maint_op_reg    <= '0;
        maint_ext_reg   <= 1'b0;
        maint_count_reg <= 8'h00;
      end else if (wr && mop != M_NONE) begin
        maint_op_reg    <= NMAINT'(1) << mop;
        maint_ext_reg   <= COH_OPS[mop] || (UNI_OPS[mop] && inner_broadcast_cfg_i);
        maint_count_reg <= maint_count_reg + 8'h01;
      end else begin
        maint_op_reg    <= '0;
        maint_ext_reg   <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        maint_data_reg <= 32'h0000_0000;
      end else if (wr && mop != M_NONE) begin
        maint_data_reg <= wb_dat_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (srst_i) begin
        pou_ext_reg    <= 1'b0;
        tbc_active_reg <= 32'h0000_0000;
      end else begin
        pou_ext_reg    <= inner_broadcast_cfg_i;
        tbc_active_reg <= nonsecure_view_reg ? tbc_ns : regs_q[S_TBCS];
      end
    end
  end

  assign wb_ack_o                   = ack_reg;
  assign wb_dat_o                   = rdata_reg;
  assign system_control_o           = regs_q[S_SYSCTL];
  assign translation_base_control_o = tbc_active_reg;
  assign maint_op_o                 = maint_op_reg;
  assign maint_data_o               = maint_data_reg;
  assign maint_external_o           = maint_ext_reg;
  assign pou_external_o             = pou_ext_reg;

endmodule

// >>> vmfcsb_bank_assertions.sv
/*
  Concurrent checks on the bank's handshake, reset values and maintenance pulses.
  Assumes one clock; the bind at the foot attaches it to every bank instance.
*/
`timescale 1ns/1ps
module vmfcsb_checker (
  input wire logic                          clk_i,
  input wire logic                          srst_i,
  input wire logic                          ce_i,
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_we_i,
  input wire logic                          wb_ack_o,
  input wire logic                          exception_state_select_i,
  input wire logic                          endianness_select_i,
  input wire logic                          high_vector_select_i,
  input wire logic                          inner_broadcast_cfg_i,
  input wire logic [31:0]                   system_control_o,
  input wire logic [31:0]                   translation_base_control_o,
  input wire logic [vmfcsb_pkg::NMAINT-1:0] maint_op_o,
  input wire logic                          maint_external_o,
  input wire logic                          pou_external_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ack_one_cycle_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a one-cycle answer");
  ack_needs_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without a request");
  maint_on_write_a: assert property (maint_op_o != 0 |-> wb_ack_o && $past(wb_we_i))
    else $error("maintenance pulse without a write");
  maint_onehot_a: assert property ($onehot0(maint_op_o) and (maint_op_o != 0 |=> maint_op_o == 0))
    else $error("maintenance pulse not one-hot single cycle");
  maint_ext_a: assert property (maint_op_o != 0 |-> maint_external_o ==
    ((|(maint_op_o & 13'h0940)) || (inner_broadcast_cfg_i && (|(maint_op_o & 13'h040D)))))
    else $error("wrong external completion flag");
  ext_idle_a: assert property (maint_op_o == 0 |-> !maint_external_o)
    else $error("external flag without an operation");
  pou_follow_a: assert property (!$past(srst_i) |-> pou_external_o == $past(inner_broadcast_cfg_i))
    else $error("unification flag does not follow config");
  sysctl_reset_a: assert property (disable iff (1'b0) $past(srst_i) |-> system_control_o == (32'h00C5_0078 |
    {1'b0, exception_state_select_i, 4'h0, endianness_select_i, 11'h0, high_vector_select_i, 13'h0}))
    else $error("system control reset value wrong");
  tbc_reset_a: assert property (disable iff (1'b0) $past(srst_i) |-> translation_base_control_o == 32'h0)
    else $error("translation base control not cleared by reset");
endmodule

bind vmfcsb_bank vmfcsb_checker vmfcsb_checker_i (.*);

// >>> tb_top.sv
/*
  Bench for the register bank: reset values, decode, byte lanes, shared encodings, maintenance.
  Assumes a classic Wishbone slave answering every request with a one-cycle ack.
*/
`timescale 1ns/1ps
module tb_top;
  import vmfcsb_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [16:0] adr = '0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = '0;
  logic        te = 1'b0;
  logic        ee = 1'b0;
  logic        hv = 1'b0;
  logic        bc = 1'b0;
  logic [31:0] rd_bus, sctl, tbc, mdat_w, rdat, mdat;
  logic [12:0] mop_w, mop;
  logic        ack, mext_w, point_of_unification, mext;
  int          num_errors = 0;
  int          cmp_count = 0;
  logic [7:0]  mt [13] = '{8'h10, 8'h16, 8'h50, 8'h51, 8'h56, 8'h57, 8'h61, 8'h62, 8'hA1, 8'hA2, 8'hB1, 8'hE1, 8'hE2};
  logic [12:0] coh_m = 13'h0940;
  logic [12:0] uni_m = 13'h040D;
  logic [16:0] wk [15];

  vmfcsb_bank #(.SIMD_PRESENT(1'b0)) vmfcsb_bank_i (.clk_i(clk), .srst_i(srst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_bus),
    .wb_ack_o(ack), .exception_state_select_i(te), .endianness_select_i(ee), .high_vector_select_i(hv),
    .inner_broadcast_cfg_i(bc), .system_control_o(sctl), .translation_base_control_o(tbc),
    .maint_op_o(mop_w), .maint_data_o(mdat_w), .maint_external_o(mext_w), .pou_external_o(point_of_unification));

  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic [16:0] ra(input int crn, input int op1, input int crm, input int op2);
    ra = {1'b0, crn[3:0], op1[2:0], crm[3:0], op2[2:0], 2'b00};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [16:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      num_errors++;
      $display("ERROR %0t: no ack", $time);
    end
    rdat = rd_bus;
    mop = mop_w;
    mdat = mdat_w;
    mext = mext_w;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [16:0] a, input logic [31:0] d);
    xfer(1'b1, a, 4'hF, d);
  endtask

  task automatic rd(input logic [16:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 4'h0, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic do_reset;
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask

  task automatic maint_pass(input logic b);
    for (int i = 0; i < 13; i++) begin
      wr(ra(7, 0, mt[i][7:4], mt[i][2:0]), 32'h0000_1000 + i);
      chk({19'h0, mop}, 32'h1 << i);
      chk(mdat, 32'h0000_1000 + i);
      chk({31'h0, mext}, {31'h0, coh_m[i] | (b & uni_m[i])});
    end
    rd(ra(7, 0, 5, 0), 32'h0);
    chk({31'h0, point_of_unification}, {31'h0, b});
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    $display("ERROR %0t: timeout", $time);
    wrap_up();
  end

  initial begin
    wk = '{ra(3, 0, 0, 0), ra(5, 0, 0, 0), ra(5, 0, 0, 1), ra(5, 0, 1, 0), ra(5, 0, 1, 1), ra(6, 0, 0, 0),
           ra(6, 0, 0, 2), ra(10, 0, 3, 0), ra(10, 0, 3, 1), ra(13, 0, 0, 1), ra(2, 0, 0, 0), ra(2, 0, 0, 1),
           ra(1, 0, 0, 0), ra(1, 0, 0, 2), ra(13, 0, 0, 0)};
    do_reset();
    rd(ra(1, 0, 0, 0), 32'h00C5_0078);
    chk(sctl, 32'h00C5_0078);
    rd(ra(10, 0, 2, 0), 32'h0009_8AA4);
    rd(ra(10, 0, 2, 1), 32'h44E0_48E0);
    rd(ra(2, 0, 0, 2), 32'h0);
    rd(ra(13, 0, 0, 0), 32'h0);
    rd(ra(1, 0, 0, 2), 32'h8000_0000);
    rd(ra(9, 0, 0, 0), 32'h0);
    foreach (wk[i]) wr(wk[i], 32'h5A3C_0000 | (i * 32'h0000_0111));
    foreach (wk[i]) rd(wk[i], 32'h5A3C_0000 | (i * 32'h0000_0111));
    xfer(1'b1, ra(3, 0, 0, 0), 4'h2, 32'hFFFF_FFFF);
    rd(ra(3, 0, 0, 0), 32'h5A3C_FF00);
    wr(ra(2, 0, 0, 0), 32'h1234_5678);
    rd(ra(0, 0, 2, 0) | 17'h1_0000, 32'h1234_5678);
    wr(ra(0, 1, 2, 1) | 17'h1_0000, 32'h0000_00C3);
    rd(ra(0, 1, 2, 1) | 17'h1_0000, 32'h0000_00C3);
    rd(ra(2, 0, 0, 1), 32'h5A3C_0BBB);
    wr(ra(2, 0, 0, 2), 32'h8000_0000);
    wr(ra(10, 0, 2, 0), 32'hCAFE_0001);
    wr(ra(10, 0, 2, 1), 32'hCAFE_0002);
    rd(ra(10, 0, 2, 0), 32'hCAFE_0001);
    rd(ra(10, 0, 2, 1), 32'hCAFE_0002);
    chk(tbc, 32'h8000_0000);
    wr(ra(2, 0, 0, 2), 32'h0);
    rd(ra(10, 0, 2, 0), 32'h0009_8AA4);
    rd(ra(10, 0, 2, 1), 32'h44E0_48E0);
    wr(ra(15, 7, 15, 0), 32'h1);
    xfer(1'b0, ra(2, 0, 0, 2), 4'h0, 32'h0);
    chk({31'h0, rdat[31]}, 32'h0);
    wr(ra(2, 0, 0, 2), 32'h0000_0005);
    rd(ra(2, 0, 0, 2), 32'h0000_0005);
    chk(tbc, 32'h0000_0005);
    wr(ra(15, 7, 15, 0), 32'h0);
    rd(ra(2, 0, 0, 2), 32'h0);
    maint_pass(1'b0);
    te <= 1'b1;
    ee <= 1'b1;
    hv <= 1'b1;
    bc <= 1'b1;
    do_reset();
    rd(ra(1, 0, 0, 0), 32'h42C5_2078);
    chk(sctl, 32'h42C5_2078);
    maint_pass(1'b1);
    wrap_up();
  end
endmodule
